/* anadv_asserts.sv */
`timescale 1ns/1ps

module anadv_asserts
(
    input wire logic        REF_CLK_IN,
    input wire logic        SYS_RST_IN,
    input wire logic [4:0]  REG_ADDR_IN,
    input wire logic        REG_WR_IN,
    input wire logic [15:0] REG_WDATA_IN,
    input wire logic        REG_HIT_OUT,
    input wire logic [15:0] REG_RDATA_OUT,
    input wire logic [15:0] LOCAL_ABILITY_WORD_OUT,
    input wire logic        ADVERT_READY_OUT
);
    wire [15:0] w = LOCAL_ABILITY_WORD_OUT;
    wire [15:0] r = REG_RDATA_OUT;
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    property p_rsvd14; !r[14] && !w[14]; endproperty
    a_rsvd14: assert property (p_rsvd14) else $error("bit 14 set");
    property p_rsvd; r[12:11] == 2'h0 && w[12:11] == 2'h0; endproperty
    a_rsvd: assert property (p_rsvd) else $error("bits 12:11 set");
    property p_t4; !r[9] && !w[9]; endproperty
    a_t4: assert property (p_t4) else $error("bit 9 set");
    property p_rst; disable iff (1'b0) SYS_RST_IN |=> !ADVERT_READY_OUT && w == 16'h0000; endproperty
    a_rst: assert property (p_rst) else $error("outputs live in reset");
    // Fixed fields must already hold their defaults when writes open up
    property p_rdy; $rose(ADVERT_READY_OUT) |-> (w & 16'hfe1f) == 16'h0001; endproperty
    a_rdy: assert property (p_rdy) else $error("bad default word");
    property p_wr; ADVERT_READY_OUT && REG_WR_IN && REG_ADDR_IN == 5'h04 |-> ##2 w == ($past(REG_WDATA_IN, 2) & 16'ha5ff); endproperty
    a_wr: assert property (p_wr) else $error("write not stored");
    property p_hold; (ADVERT_READY_OUT && !REG_WR_IN) [*3] |=> $stable(w); endproperty
    a_hold: assert property (p_hold) else $error("word moved");
    property p_hit; REG_ADDR_IN == 5'h04 |=> REG_HIT_OUT && r == w; endproperty
    a_hit: assert property (p_hit) else $error("read differs from word");
    property p_miss; REG_ADDR_IN != 5'h04 |=> !REG_HIT_OUT && r == 16'h0000; endproperty
    a_miss: assert property (p_miss) else $error("foreign address hit");
endmodule

/* anadv_if.sv */
`timescale 1ns/1ps

// Carries the strap-derived ability defaults between the decoder and the bank
interface anadv_strap_if;
    import anadv_pkg::*;

    anadv_ability_t ability;

    modport decoder (output ability);
    modport bank    (input  ability);
endinterface

/* anadv_mgmt_model.sv */
`timescale 1ns/1ps

module anadv_mgmt_model
    import anadv_pkg::*;
(
    input  wire logic                   clk_in,
    input  wire logic                   hit_in,
    input  wire anadv_pkg::anadv_word_t rdata_in,
    output anadv_pkg::anadv_addr_t      addr_out,
    output logic                        wr_out,
    output anadv_pkg::anadv_word_t      wdata_out
);
    initial
    begin
        addr_out = 5'h00;
        wr_out = 1'b0;
        wdata_out = 16'h0000;
    end
    // Raw mode lets a test break the zero-write habit on purpose
    task automatic write_reg(input anadv_word_t v, input logic raw);
        @(negedge clk_in);
        addr_out = 5'h04;
        wr_out = 1'b1;
        wdata_out = raw ? v : (v & 16'he7ff);
        @(negedge clk_in);
        wr_out = 1'b0;
        wdata_out = ~wdata_out;
    endtask
    task automatic read_reg(input anadv_addr_t a, output anadv_word_t v, output logic h);
        @(negedge clk_in);
        addr_out = a;
        @(negedge clk_in);
        v = rdata_in;
        h = hit_in;
    endtask
endmodule

/* anadv_pkg.sv */
package anadv_pkg;

    typedef logic [15:0] anadv_word_t;
    typedef logic [4:0]  anadv_addr_t;
    typedef logic [3:0]  anadv_ability_t;

    typedef enum logic [1:0]
    {
        ANADV_ST_RESET = 2'h0,
        ANADV_ST_LOAD  = 2'h1,
        ANADV_ST_RUN   = 2'h3
    } anadv_state_t;

endpackage

/* anadv_regs.svh */
`ifndef ANADV_REGS_SVH
`define ANADV_REGS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define ANADV_ADDR_LOCAL_ABILITY   5'h04

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ANADV_BIT_NEXT_PAGE        15
`define ANADV_BIT_RSVD_FIXED       14
`define ANADV_BIT_REMOTE_FAULT     13
`define ANADV_BIT_RSVD_HI          12
`define ANADV_BIT_RSVD_LO          11
`define ANADV_BIT_PAUSE            10
`define ANADV_BIT_FOUR_PAIR        9
`define ANADV_BIT_FAST_FD          8
`define ANADV_BIT_FAST_HD          7
`define ANADV_BIT_TEN_FD           6
`define ANADV_BIT_TEN_HD           5
`define ANADV_SEL_MSB              4
`define ANADV_SEL_LSB              0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ANADV_RST_NEXT_PAGE        1'h0
`define ANADV_RST_REMOTE_FAULT     1'h0
`define ANADV_RST_PAUSE            1'h0
`define ANADV_RST_SELECTOR         5'h01

// Strap decode: index {one,zero}, value {fast_fd,fast_hd,ten_fd,ten_hd}
`define ANADV_STRAP_TABLE_0        4'h1
`define ANADV_STRAP_TABLE_1        4'h3
`define ANADV_STRAP_TABLE_2        4'h6
`define ANADV_STRAP_TABLE_3        4'hf

`endif

/* anadv_strap_decode.sv */
`timescale 1ns/1ps
`include "anadv_regs.svh"

module anadv_strap_decode
    import anadv_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        strap_zero_in,
    input  wire logic        strap_one_in,
    anadv_strap_if.decoder   strap_out
);
    // ----------------------------------------------------------------
    // Strap synchroniser and decode table
    // ----------------------------------------------------------------
    // Table is fixed at elaboration; straps are pins so they are resynced
    localparam anadv_ability_t STRAP_TABLE [4] = '{
        `ANADV_STRAP_TABLE_0, `ANADV_STRAP_TABLE_1,
        `ANADV_STRAP_TABLE_2, `ANADV_STRAP_TABLE_3};

    logic [1:0] meta_q;
    logic [1:0] sync_q;

    always_ff @(posedge clk_in)
    begin
        meta_q <= {strap_one_in, strap_zero_in};
        sync_q <= meta_q;
    end

    assign strap_out.ability = STRAP_TABLE[sync_q];
endmodule

/* anadv_top.sv */
`timescale 1ns/1ps
`include "anadv_regs.svh"


module anadv_top
    import anadv_pkg::*;
(
    input  wire logic              REF_CLK_IN,
    input  wire logic              SYS_RST_IN,
    input  wire logic              AUTONEG_STRAP_ZERO_IN,
    input  wire logic              AUTONEG_STRAP_ONE_IN,
    input  wire anadv_pkg::anadv_addr_t REG_ADDR_IN,
    input  wire logic              REG_WR_IN,
    input  wire anadv_pkg::anadv_word_t REG_WDATA_IN,
    output logic                   REG_HIT_OUT,
    output anadv_pkg::anadv_word_t REG_RDATA_OUT,
    output anadv_pkg::anadv_word_t LOCAL_ABILITY_WORD_OUT,
    output logic                   ADVERT_READY_OUT
);
    import anadv_pkg::*;

    // ----------------------------------------------------------------
    // Strap decode
    // ----------------------------------------------------------------
    anadv_strap_if strap_bus ();

    anadv_strap_decode u_strap
    (
        .clk_in        (REF_CLK_IN),
        .strap_zero_in (AUTONEG_STRAP_ZERO_IN),
        .strap_one_in  (AUTONEG_STRAP_ONE_IN),
        .strap_out     (strap_bus.decoder)
    );

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    // Straps need two edges through the synchroniser before they are
    // trusted, so abilities load a few cycles after reset release.
    anadv_state_t state_q;
    anadv_state_t state_d;
    logic [1:0]   settle_q;

    wire settle_done = (settle_q == 2'h3);

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ANADV_ST_RESET: state_d = ANADV_ST_LOAD;
            ANADV_ST_LOAD:  if (settle_done) state_d = ANADV_ST_RUN;
            ANADV_ST_RUN:   state_d = ANADV_ST_RUN;
            default:        state_d = ANADV_ST_RESET;
        endcase
    end

    always_ff @(posedge REF_CLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            state_q  <= ANADV_ST_RESET;
            settle_q <= 2'h0;
        end
        else
        begin
            state_q  <= state_d;
            if (state_q == ANADV_ST_LOAD && !settle_done)
                settle_q <= settle_q + 2'h1;
        end
    end

    wire load_straps = (state_q == ANADV_ST_LOAD) && settle_done;
    wire running     = (state_q == ANADV_ST_RUN);

    // ----------------------------------------------------------------
    // Register decode
    // ----------------------------------------------------------------
    // Writes are held off until straps have loaded so a strap value never
    // overwrites an early software write.
    wire addr_hit = (REG_ADDR_IN == `ANADV_ADDR_LOCAL_ABILITY);
    wire wr_en    = REG_WR_IN && addr_hit && running;

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic           next_page_request_q;
    logic           remote_fault_advert_q;
    logic           pause_capability_advert_q;
    anadv_ability_t speed_ability_q;
    logic [4:0]     selector_q;

    always_ff @(posedge REF_CLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            next_page_request_q       <= `ANADV_RST_NEXT_PAGE;
            remote_fault_advert_q     <= `ANADV_RST_REMOTE_FAULT;
            pause_capability_advert_q <= `ANADV_RST_PAUSE;
            speed_ability_q           <= 4'h0;
            selector_q                <= `ANADV_RST_SELECTOR;
        end
        else if (load_straps)
        begin
            speed_ability_q <= strap_bus.ability;
        end
        else if (wr_en)
        begin
            next_page_request_q       <= REG_WDATA_IN[`ANADV_BIT_NEXT_PAGE];
            remote_fault_advert_q     <= REG_WDATA_IN[`ANADV_BIT_REMOTE_FAULT];
            pause_capability_advert_q <= REG_WDATA_IN[`ANADV_BIT_PAUSE];
            speed_ability_q           <= REG_WDATA_IN[`ANADV_BIT_FAST_FD:`ANADV_BIT_TEN_HD];
            selector_q                <= REG_WDATA_IN[`ANADV_SEL_MSB:`ANADV_SEL_LSB];
        end
    end

    // ----------------------------------------------------------------
    // Word assembly
    // ----------------------------------------------------------------
    // Reserved bits are not stored at all, so writes cannot reach them.
    anadv_word_t advert_word;

    always_comb
    begin
        advert_word = 16'h0000;
        advert_word[`ANADV_BIT_NEXT_PAGE]    = next_page_request_q;
        advert_word[`ANADV_BIT_REMOTE_FAULT] = remote_fault_advert_q;
        advert_word[`ANADV_BIT_PAUSE]        = pause_capability_advert_q;
        advert_word[`ANADV_BIT_FAST_FD:`ANADV_BIT_TEN_HD] = speed_ability_q;
        advert_word[`ANADV_SEL_MSB:`ANADV_SEL_LSB]       = selector_q;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    always_ff @(posedge REF_CLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            REG_HIT_OUT            <= 1'h0;
            REG_RDATA_OUT          <= 16'h0000;
            LOCAL_ABILITY_WORD_OUT <= 16'h0000;
            ADVERT_READY_OUT       <= 1'h0;
        end
        else
        begin
            REG_HIT_OUT            <= addr_hit;
            REG_RDATA_OUT          <= addr_hit ? advert_word : 16'h0000;
            LOCAL_ABILITY_WORD_OUT <= advert_word;
            ADVERT_READY_OUT       <= running;
        end
    end
endmodule

/* tb_top.sv */
`timescale 1ns/1ps
`include "anadv_regs.svh"

module tb_top;
    import anadv_pkg::*;
    logic           clk = 1'b0;
    logic           rst = 1'b1;
    logic [1:0]     strap = 2'h0;
    anadv_addr_t    addr;
    logic           wr;
    anadv_word_t    wdata, rdata, word, rd;
    logic           hit, ready, h;
    int             error_cnt = 0;
    int             n_compared = 0;
    anadv_ability_t tab [4] = '{`ANADV_STRAP_TABLE_0, `ANADV_STRAP_TABLE_1, `ANADV_STRAP_TABLE_2, `ANADV_STRAP_TABLE_3};
    anadv_word_t    rows [6][2] = '{'{16'h8000, 16'h8000}, '{16'h2000, 16'h2000}, '{16'h0400, 16'h0400},
                                    '{16'h01e0, 16'h01e0}, '{16'h001f, 16'h001f}, '{16'h0000, 16'h0000}};
    always #5 clk = ~clk;
    anadv_top u_dut (.REF_CLK_IN(clk), .SYS_RST_IN(rst), .AUTONEG_STRAP_ZERO_IN(strap[0]),
        .AUTONEG_STRAP_ONE_IN(strap[1]), .REG_ADDR_IN(addr), .REG_WR_IN(wr), .REG_WDATA_IN(wdata),
        .REG_HIT_OUT(hit), .REG_RDATA_OUT(rdata), .LOCAL_ABILITY_WORD_OUT(word), .ADVERT_READY_OUT(ready));
    anadv_mgmt_model u_mgmt (.clk_in(clk), .hit_in(hit), .rdata_in(rdata), .addr_out(addr), .wr_out(wr),
        .wdata_out(wdata));
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input anadv_word_t seen, input anadv_word_t exp);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Early write lands before the straps are loaded and must be dropped
    task automatic do_reset(input logic [1:0] s, input logic early);
        int n;
        @(negedge clk);
        strap = s;
        rst = 1'b1;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        if (early)
            u_mgmt.write_reg(16'hffff, 1'b1);
        n = 0;
        while (ready !== 1'b1 && n < 50)
        begin
            @(negedge clk);
            n++;
        end
        if (n == 50)
        begin
            error_cnt++;
            give_verdict();
        end
    endtask
    initial
    begin
        for (int s = 0; s < 4; s++)
        begin
            do_reset(s[1:0], s == 2);
            u_mgmt.read_reg(5'h04, rd, h);
            check(rd, {7'h00, tab[s], 5'h01});
            check(word, rd);
            $display("strap case %0d done", s);
        end
        foreach (rows[i])
        begin
            u_mgmt.write_reg(rows[i][0], 1'b0);
            u_mgmt.read_reg(5'h04, rd, h);
            check(rd, rows[i][1]);
            check({15'h0000, h}, 16'h0001);
            check(word, rows[i][1]);
        end
        $display("row table done");
        u_mgmt.write_reg(16'hffff, 1'b1);
        u_mgmt.read_reg(5'h04, rd, h);
        check(rd, 16'ha5ff);
        u_mgmt.read_reg(5'h05, rd, h);
        check({15'h0000, h}, 16'h0000);
        check(rd, 16'h0000);
        $display("reserved and foreign reads done");
        do_reset(2'h1, 1'b0);
        u_mgmt.read_reg(5'h04, rd, h);
        check(rd, {7'h00, tab[1], 5'h01});
        $display("second reset done");
        give_verdict();
    end
endmodule

bind anadv_top anadv_asserts u_asserts (.REF_CLK_IN(REF_CLK_IN), .SYS_RST_IN(SYS_RST_IN), .REG_ADDR_IN(REG_ADDR_IN),
    .REG_WR_IN(REG_WR_IN), .REG_WDATA_IN(REG_WDATA_IN), .REG_HIT_OUT(REG_HIT_OUT), .REG_RDATA_OUT(REG_RDATA_OUT),
    .LOCAL_ABILITY_WORD_OUT(LOCAL_ABILITY_WORD_OUT), .ADVERT_READY_OUT(ADVERT_READY_OUT));
